//--- dacdb_host.sv
// host model: the controlling microcontroller's write port and load strobe pin
`timescale 1ns/10ps
`default_nettype none
module dacdb_host (
   input wire logic mclk_i, // system clock
   output var logic wr_stb_o, otp_wr_o, load_strobe_pin_n_o, // strobe, otp select, pin
   output var logic [4:0] wr_addr_o, // address
   output var logic [15:0] wr_data_o // data word
);
   // pin rests high so no falling edge fakes a pin transfer
   initial {wr_stb_o, otp_wr_o, wr_addr_o, wr_data_o, load_strobe_pin_n_o} = 24'h00_0001;
   // trigger bit only where the caller asks for it
   task wr(input logic [4:0] a, input logic [15:0] d, input logic o);
      @(posedge mclk_i);
      #1 {wr_stb_o, otp_wr_o, wr_addr_o, wr_data_o} = {1'b1, o, a, d};
      @(posedge mclk_i);
      // released bus shows junk, not the last word
      #1 {wr_stb_o, wr_addr_o, wr_data_o} = {1'b0, ~a, ~d};
   endtask
   // low pulse of half a 160 ns link period
   task pulse;
      #1 load_strobe_pin_n_o = 1'b0;
      #80 load_strobe_pin_n_o = 1'b1;
   endtask
endmodule // dacdb_host
`default_nettype wire

//--- dacdb_map.vh
// constants for the dac double-buffer update block
`ifndef DACDB_MAP_VH
`define DACDB_MAP_VH
`define DACDB_CODE_W 10
`define DACDB_DATA_W 16
`define DACDB_ADDR_W 5
`define DACDB_TRIG_BIT 15
`define DACDB_NCH 16
`define DACDB_NGAMMA 14
`define DACDB_CODE_ZERO 10'h000
`define DACDB_ADDR_GLAST 5'h0d
`define DACDB_ADDR_COM1 5'h12
`define DACDB_ADDR_COM2 5'h13
`define DACDB_ADDR_WDIS 5'h14
`define DACDB_IDX_COM1 4'he
`define DACDB_IDX_COM2 4'hf
`define DACDB_IDX_HI 3
`define DACDB_WDIS_BIT 0
`endif

//--- dacdb_update.v
// dac double-buffer update: input bank, output bank, load strobe and otp defaults
`timescale 1ns/10ps
`default_nettype none
`include "dacdb_map.vh"
// Functional notes
// - writes go to input bank; otp writes also load the output
// - load strobe pin transfers all channels
// - data bit 15 write triggers transfer
// - all outputs update together after write
// - power-up loads otp value or zero
// - common-voltage channels have own registers
// - codes storable in otp memory
// - gamma 00000-01101, common 10010-10011, disable 10100
// - otp write also updates dac output
// - read returns applied dac code
module dacdb_update #(
   parameter NCH = `DACDB_NCH, // channel count, gamma plus common
   parameter CW = `DACDB_CODE_W // code width
) (
   input wire mclk_i, // system clock
   input wire rst_n_i, // async reset, active low
   input wire wr_stb_i, // one-cycle write strobe, after final data bit
   input wire otp_wr_i, // write targets otp (with dac), else dac input
   input wire [`DACDB_ADDR_W-1:0] wr_addr_i, // register address
   input wire [`DACDB_DATA_W-1:0] wr_data_i, // 16-bit write data
   input wire [`DACDB_ADDR_W-1:0] rd_addr_i, // read address
   input wire load_strobe_pin_n_i, // load strobe pin, async, active low
   input wire [NCH-1:0] otp_valid_i, // per channel: otp was programmed
   input wire [NCH*CW-1:0] otp_code_i, // per channel stored otp codes
   output reg [NCH*CW-1:0] dac_code_o, // applied dac codes, ch0 lsb
   output reg [CW-1:0] rd_data_o, // applied code of read address
   output reg rd_valid_o, // read address maps to a channel
   output reg [NCH-1:0] otp_prog_o, // one-cycle otp program pulses
   output reg [CW-1:0] otp_prog_data_o, // code to program into otp
   output reg wr_dis_o // otp write disable bit
);
   reg rst_s1_q; // reset release stage 1
   reg rst_s2_q; // synchronised reset
   wire rst_n; // internal reset
   reg ld_s1_q; // load strobe sync stage 1
   reg ld_s2_q; // load strobe sync stage 2
   reg ld_s3_q; // previous synced value for edge detect
   reg init_q; // power-up load pending
   reg [NCH*CW-1:0] in_bank_q; // first register bank
   reg [3:0] idx; // decoded channel index
   reg hit; // address maps to a channel
   reg [3:0] ridx; // read channel index
   reg rhit; // read address valid
   wire trig_sw; // software transfer trigger
   wire trig_hw; // load strobe falling edge
   wire [CW-1:0] wcode; // stored portion of write data
   // trade-off: read mux spans all channels, small at this count

   // reset released through two flops; asserts asynchronously
   // no other process sees rst_n_i directly, so release is clean
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // address decode for writes
   always @*
   begin
      // defaults: low address bits pick a gamma channel, nothing hit
      idx = wr_addr_i[`DACDB_IDX_HI:0];
      hit = 1'b0;
      // channel address map; gaps and the disable address hit nothing
      if (wr_addr_i <= `DACDB_ADDR_GLAST)
         // gamma channels map straight onto their index
         hit = 1'b1;
      // common-voltage channels sit above the gamma block
      else if (wr_addr_i == `DACDB_ADDR_COM1)
      begin
         idx = `DACDB_IDX_COM1;
         hit = 1'b1;
      end
      else if (wr_addr_i == `DACDB_ADDR_COM2)
      begin
         idx = `DACDB_IDX_COM2;
         hit = 1'b1;
      end
   end

   // address decode for reads
   always @*
   begin
      // defaults: gamma index from low bits, not a channel
      ridx = rd_addr_i[`DACDB_IDX_HI:0];
      rhit = 1'b0;
      // same map as the write side
      if (rd_addr_i <= `DACDB_ADDR_GLAST)
         // gamma channel read
         rhit = 1'b1;
      // common-voltage channels
      else if (rd_addr_i == `DACDB_ADDR_COM1)
      begin
         ridx = `DACDB_IDX_COM1;
         rhit = 1'b1;
      end
      else if (rd_addr_i == `DACDB_ADDR_COM2)
      begin
         ridx = `DACDB_IDX_COM2;
         rhit = 1'b1;
      end
   end

   assign wcode = wr_data_i[CW-1:0];
   assign trig_sw = wr_stb_i & ~otp_wr_i & hit & wr_data_i[`DACDB_TRIG_BIT];
   // strobe edge triggers; falling edge used so a line parked high is idle
   assign trig_hw = ld_s3_q & ~ld_s2_q;

   // load strobe synchroniser; only stage 2 feeds the edge detector
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // parked at the idle high level so reset never fakes an edge
         ld_s1_q <= 1'b1;
         ld_s2_q <= 1'b1;
         ld_s3_q <= 1'b1;
      end
      else
      begin
         ld_s1_q <= load_strobe_pin_n_i;
         ld_s2_q <= ld_s1_q;
         ld_s3_q <= ld_s2_q;
      end
   end

   // per-channel input and output banks
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : g_ch
         wire wsel = wr_stb_i & hit & (idx == g);
         // boot value: stored code if programmed, zero otherwise
         wire [CW-1:0] boot = otp_valid_i[g] ? otp_code_i[g*CW +: CW] : `DACDB_CODE_ZERO;
         always @(posedge mclk_i or negedge rst_n)
         begin
            if (!rst_n)
               in_bank_q[g*CW +: CW] <= `DACDB_CODE_ZERO;
            else if (init_q)
               in_bank_q[g*CW +: CW] <= boot;
            else if (wsel)
               in_bank_q[g*CW +: CW] <= wcode;
         end
         // simultaneous update; common channels use same path
         always @(posedge mclk_i or negedge rst_n)
         begin
            if (!rst_n)
               dac_code_o[g*CW +: CW] <= `DACDB_CODE_ZERO;
            else if (init_q)
               dac_code_o[g*CW +: CW] <= boot;
            else if (wsel & otp_wr_i)
               dac_code_o[g*CW +: CW] <= wcode;
            else if (trig_sw)
               dac_code_o[g*CW +: CW] <= wsel ? wcode : in_bank_q[g*CW +: CW];
            // pin load copies the input bank unchanged; software wins a tie
            else if (trig_hw)
               dac_code_o[g*CW +: CW] <= in_bank_q[g*CW +: CW];
         end
         always @(posedge mclk_i or negedge rst_n)
         begin
            if (!rst_n)
               otp_prog_o[g] <= 1'b0;
            // program pulses are refused once the disable bit is set
            else
               otp_prog_o[g] <= wsel & otp_wr_i & ~wr_dis_o;
         end
      end
   endgenerate

   // power-up load, write-disable bit, otp data, readback
   always @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         init_q <= 1'b1;
         wr_dis_o <= 1'b0;
         otp_prog_data_o <= `DACDB_CODE_ZERO;
         rd_data_o <= `DACDB_CODE_ZERO;
         rd_valid_o <= 1'b0;
      end
      else
      begin
         // power-up load lasts exactly one cycle after reset lets go
         init_q <= 1'b0;
         if (wr_stb_i & otp_wr_i & (wr_addr_i == `DACDB_ADDR_WDIS) & wr_data_i[`DACDB_WDIS_BIT])
            wr_dis_o <= 1'b1;
         // data follows every write; only the pulse marks a real program
         otp_prog_data_o <= wcode;
         // read lags one edge, so it trails a transfer by a cycle
         // applied code read
         rd_data_o <= dac_code_o[ridx*CW +: CW];
         rd_valid_o <= rhit;
      end
   end
endmodule // dacdb_update
`default_nettype wire

//--- dacdb_update_bench.sv
// self-checking bench for the dac double-buffer update block
`timescale 1ns/10ps
`default_nettype none
module dacdb_update_bench;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, stb, owr, ld_n, rdv, dis;
   logic [4:0] wa, ra = 5'h00;
   logic [15:0] wd, pp, ov = 16'h5555;
   logic [159:0] oc, dac;
   logic [9:0] rdd, pd, ex [16];
   int bad_count = 0, compares = 0;
   always #2.5 mclk_i = ~mclk_i;
   dacdb_host host (.mclk_i(mclk_i), .wr_stb_o(stb), .otp_wr_o(owr), .wr_addr_o(wa), .wr_data_o(wd),
      .load_strobe_pin_n_o(ld_n));
   dacdb_update dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_stb_i(stb), .otp_wr_i(owr), .wr_addr_i(wa),
      .wr_data_i(wd), .rd_addr_i(ra), .load_strobe_pin_n_i(ld_n), .otp_valid_i(ov), .otp_code_i(oc),
      .dac_code_o(dac), .rd_data_o(rdd), .rd_valid_o(rdv), .otp_prog_o(pp), .otp_prog_data_o(pd), .wr_dis_o(dis));
   task chk(input logic [15:0] g, e);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   // compare every channel against the expected bank
   task all_ch;
      for (int i = 0; i < 16; i++) chk(dac[i*10 +: 10], ex[i]);
   endtask
   task final_report;
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task t_preload;
      for (int i = 0; i < 14; i++) host.wr(5'(i), 16'h0200 + 16'(i), 1'b0);
      all_ch();
      host.wr(5'h0d, 16'hfe0d, 1'b0);
      for (int i = 0; i < 14; i++) ex[i] = 10'h200 + 10'(i);
      all_ch();
   endtask
   task t_pin;
      host.wr(5'h12, 16'h0155, 1'b0);
      host.wr(5'h13, 16'h02aa, 1'b0);
      all_ch();
      host.pulse();
      ex[14] = 10'h155;
      ex[15] = 10'h2aa;
      all_ch();
      host.wr(5'h12, 16'h8099, 1'b0);
      ex[14] = 10'h099;
      all_ch();
   endtask
   task t_otp;
      host.wr(5'h02, 16'h4123, 1'b1);
      chk(pp, 16'h0004);
      chk(16'(pd), 16'h0123);
      chk(16'(dac[20 +: 10]), 16'h0123);
      host.wr(5'h14, 16'h4001, 1'b1);
      host.wr(5'h03, 16'h4066, 1'b1);
      chk(pp, 16'h0000);
      chk(16'(dis), 16'h0001);
      ra = 5'h03;
      @(posedge mclk_i);
      #1 chk(16'(rdd), 16'h0066);
      ra = 5'h10;
      @(posedge mclk_i);
      #1 chk(16'(rdv), 16'h0000);
   endtask
   initial
   begin
      for (int i = 0; i < 16; i++) oc[i*10 +: 10] = 10'(i * 37 + 1);
      for (int i = 0; i < 16; i++) ex[i] = ov[i] ? 10'(i * 37 + 1) : 10'h000;
      repeat (2) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
      repeat (4) @(posedge mclk_i);
      #1 all_ch();
      t_preload();
      t_pin();
      t_otp();
      final_report();
   end
   // watchdog well beyond the roughly 66 cycles (about 330 ns) the tests need
   initial
   begin
      #20000 bad_count++;
      final_report();
   end
endmodule // dacdb_update_bench
`default_nettype wire

//--- dacdb_update_sva.sv
// checker: port-level properties of the dac double-buffer update block
`timescale 1ns/10ps
`default_nettype none
module dacdb_update_sva #(parameter NCH = 16, parameter CW = 10) (
   input wire mclk_i, rst_n_i, wr_stb_i, otp_wr_i, load_strobe_pin_n_i, rd_valid_o, wr_dis_o,
   input wire [4:0] wr_addr_i, rd_addr_i,
   input wire [15:0] wr_data_i,
   input wire [NCH*CW-1:0] dac_code_o,
   input wire [CW-1:0] rd_data_o, otp_prog_data_o,
   input wire [NCH-1:0] otp_prog_o
);
   reg [2:0] up_q; // edges since reset let go
   // stay quiet until the reset copy has let go and defaults are loaded
   wire live = up_q[2];
   wire rd_ok = rd_addr_i < 5'h0e || rd_addr_i == 5'h12 || rd_addr_i == 5'h13;
   wire gw = wr_stb_i && wr_addr_i < 5'h0e; // gamma write taken
   always @(posedge mclk_i or negedge rst_n_i)
      if (!rst_n_i) up_q <= 3'h0;
      else if (!live) up_q <= up_q + 3'h1;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!live);
   AST_SW_LOAD: assert property (gw && !otp_wr_i && wr_data_i[15] |=>
      dac_code_o[$past(wr_addr_i[3:0])*CW +: CW] == $past(wr_data_i[CW-1:0])) else $error("trigger not applied");
   AST_HOLD: assert property (load_strobe_pin_n_i[*4] ##0 (wr_stb_i && !otp_wr_i && !wr_data_i[15]) |=>
      $stable(dac_code_o)) else $error("output moved on preload");
   AST_OTP_DAC: assert property (gw && otp_wr_i |=>
      dac_code_o[$past(wr_addr_i[3:0])*CW +: CW] == $past(wr_data_i[CW-1:0])) else $error("otp write not applied");
   AST_OTP_PROG: assert property (gw && otp_wr_i && !wr_dis_o |=> otp_prog_o == 16'h0001 << $past(wr_addr_i)
      && otp_prog_data_o == $past(wr_data_i[CW-1:0])) else $error("otp program pulse wrong");
   AST_NO_PROG: assert property (wr_dis_o |=> otp_prog_o == 0) else $error("program while disabled");
   AST_RD_DATA: assert property (rd_addr_i < 5'h0e |=>
      rd_data_o == $past(dac_code_o[rd_addr_i[3:0]*CW +: CW])) else $error("read data wrong");
   AST_RD_VALID: assert property (1'b1 |=> rd_valid_o == $past(rd_ok)) else $error("read valid wrong");
   AST_COM_LOAD: assert property (wr_stb_i && wr_addr_i == 5'h12 && wr_data_i[15] |=>
      dac_code_o[14*CW +: CW] == $past(wr_data_i[CW-1:0])) else $error("common trigger wrong");
   cover property (wr_stb_i && wr_data_i[15]);
   cover property ($fell(load_strobe_pin_n_i));
   cover property (wr_dis_o);
endmodule // dacdb_update_sva
bind dacdb_update dacdb_update_sva #(.NCH(NCH), .CW(CW)) chk (.*);
`default_nettype wire
